// file: src/rvsp_map.svh
`ifndef RVSP_MAP_SVH
`define RVSP_MAP_SVH

// Frame layout
`define RVSP_FRAME_W        16
`define RVSP_TEST_BIT       15
`define RVSP_SRC_BIT        14
`define RVSP_CHAN_HI        13
`define RVSP_CHAN_LO        10
`define RVSP_CODE_HI        9
`define RVSP_CODE_LO        0
`define RVSP_NUM_CHAN       10

// Refresh oscillator timing
`define RVSP_SYS_CLK_HZ     125000000
`define RVSP_OSC_HZ         21000
`define RVSP_OSC_HALF_CYC   (`RVSP_SYS_CLK_HZ / (2 * `RVSP_OSC_HZ))

// Register byte offsets
`define RVSP_OFS_CTRL       8'h00
`define RVSP_OFS_STATUS     8'h04
`define RVSP_OFS_LAST       8'h08
`define RVSP_OFS_CODE0      8'h40

// Field positions and reset values
`define RVSP_CTRL_REFR_EN   0
`define RVSP_CTRL_RESET     1'h1
`define RVSP_STAT_SRC       0
`define RVSP_STAT_OE        1
`define RVSP_STAT_IDX_LO    4
`define RVSP_STAT_REJ_LO    8

// AXI responses
`define RVSP_RESP_OKAY      2'h0
`define RVSP_RESP_SLVERR    2'h2

`endif

// file: src/rvsp_pkg.sv
package rvsp_pkg;
   // Refresh clock source
   typedef enum logic {
      RVSP_SRC_INT = 1'b0,
      RVSP_SRC_EXT = 1'b1
   } rvsp_src_e;

   typedef logic [15:0] rvsp_frame_t;  // One serial frame
   typedef logic [9:0]  rvsp_code_t;   // Output code
   typedef logic [3:0]  rvsp_chan_t;   // Channel number
endpackage : rvsp_pkg

// file: src/rvsp_top.sv
// Function
// - Shift serial input on rising clock while strobe low
// - Strobe rise transfers frame to addressed channel
// - Shift clock gated off while strobe high
// - Chain output shows input on 16th falling edge
// - All chained devices update on strobe rise
// - Source select 0 runs internal 21 kHz oscillator
// - Refresh pin inputs external, outputs internal clock
// - Serial input ignored unless strobe low
// - Frame: test, source, channel, 10-bit code
// - Power-up internal mode, pin released; bit 14 selects
// - Refresh one channel per refresh cycle, rotating
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "rvsp_map.svh"

module rvsp_top
   import rvsp_pkg::*;
(
   // System clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Serial link, shift clock is its own domain
   input  wire logic        shift_clk,
   input  wire logic        load_strobe_n,
   input  wire logic        serial_in,
   output logic             serial_chain_out,
   // Refresh clock pin, split into three signals
   input  wire logic        refresh_clock_pin_in,
   output logic             refresh_clock_pin_out,
   output logic             refresh_clock_pin_oe,
   // Refresh slot towards the sample-and-hold stage
   output logic [3:0]       refresh_channel,
   output logic [9:0]       refresh_code,
   output logic             refresh_strobe,
   output logic             refresh_source_select,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // Frame is usable: test bit clear and channel implemented
   function automatic logic frame_ok(input rvsp_frame_t f);
      frame_ok = !f[`RVSP_TEST_BIT] &&
                 (f[`RVSP_CHAN_HI:`RVSP_CHAN_LO] < 4'(`RVSP_NUM_CHAN));
   endfunction : frame_ok

   // Register index of a code slot, or all ones when not a code slot
   function automatic logic [4:0] code_slot(input logic [7:0] a);
      if (a >= `RVSP_OFS_CODE0 && a < (`RVSP_OFS_CODE0 + 8'(4 * `RVSP_NUM_CHAN)) && a[1:0] == 2'h0) begin
         code_slot = {1'b0, 4'((a - `RVSP_OFS_CODE0) >> 2)};
      end else begin
         code_slot = 5'h1f;
      end
   endfunction : code_slot

   // ---------------- Link domain ----------------
   rvsp_frame_t shift_r;        // 16-stage shift register
   logic        chain_r;        // Buffered last stage

   // Shift only while the strobe is low; no other edge moves it
   always_ff @(posedge shift_clk or posedge rst) begin
      if (rst) begin
         shift_r <= 16'h0000;
      end else if (!load_strobe_n) begin
         shift_r <= {shift_r[14:0], serial_in};
      end
   end

   // Last stage is re-timed on the falling edge for the next device
   always_ff @(negedge shift_clk or posedge rst) begin
      if (rst) begin
         chain_r <= 1'b0;
      end else if (!load_strobe_n) begin
         chain_r <= shift_r[`RVSP_FRAME_W-1];
      end
   end

   assign serial_chain_out = chain_r;

   // ---------------- Strobe synchroniser ----------------
   logic [2:0] stb_sync_r;      // Three-stage sampler
   logic       stb_lvl_r;       // Filtered strobe level
   logic       stb_rise;        // Filtered rising edge

   // Strobe crosses into the system domain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stb_sync_r <= 3'h7;
      end else begin
         stb_sync_r <= {stb_sync_r[1:0], load_strobe_n};
      end
   end

   // Level changes only once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stb_lvl_r <= 1'b1;
      end else if (stb_sync_r[1] == stb_sync_r[2]) begin
         stb_lvl_r <= stb_sync_r[2];
      end
   end

   assign stb_rise = (stb_sync_r[1] == stb_sync_r[2]) && stb_sync_r[2] && !stb_lvl_r;

   // ---------------- Frame capture ----------------
   // The shift register is frozen while the strobe is high, so the word
   // can be read here without a word crossing of its own.
   rvsp_frame_t last_r;         // Last frame seen at a strobe rise
   logic [7:0]  reject_r;       // Count of dropped frames
   rvsp_code_t  code_r [`RVSP_NUM_CHAN];  // Channel codes
   rvsp_src_e   src_r;          // Refresh source
   logic        src_set_r;      // Source written by a frame since reset

   // Keep the raw frame for software
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last_r <= 16'h0000;
      end else if (stb_rise) begin
         last_r <= shift_r;
      end
   end

   // Count frames that were discarded
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reject_r <= 8'h00;
      end else if (stb_rise && !frame_ok(shift_r)) begin
         reject_r <= reject_r + 8'h01;
      end
   end

   // One code register per channel, loaded at the strobe rise
   for (genvar ch = 0; ch < `RVSP_NUM_CHAN; ch++) begin : g_code
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            code_r[ch] <= 10'h000;
         end else if (stb_rise && frame_ok(shift_r) &&
                      shift_r[`RVSP_CHAN_HI:`RVSP_CHAN_LO] == 4'(ch)) begin
            code_r[ch] <= shift_r[`RVSP_CODE_HI:`RVSP_CODE_LO];
         end
      end
   end

   // Source bit follows every accepted frame
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         src_r     <= RVSP_SRC_INT;
         src_set_r <= 1'b0;
      end else if (stb_rise && frame_ok(shift_r)) begin
         src_r     <= rvsp_src_e'(shift_r[`RVSP_SRC_BIT]);
         src_set_r <= 1'b1;
      end
   end

   assign refresh_source_select = src_r;

   // ---------------- Internal oscillator ----------------
   logic [11:0] osc_cnt_r;      // Half-period counter
   logic        osc_r;          // Internal refresh clock

   // Divide the system clock down to about 21 kHz
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_cnt_r <= 12'h000;
         osc_r     <= 1'b0;
      end else if (osc_cnt_r == 12'(`RVSP_OSC_HALF_CYC - 1)) begin
         osc_cnt_r <= 12'h000;
         osc_r     <= !osc_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 12'h001;
      end
   end

   // Pin drives only after a frame chose internal mode; until then it
   // stays released so two devices never fight at power-up.
   assign refresh_clock_pin_out = osc_r;
   assign refresh_clock_pin_oe  = src_set_r && (src_r == RVSP_SRC_INT);

   // ---------------- External refresh clock ----------------
   logic [2:0] ext_sync_r;      // Three-stage sampler
   logic       ext_lvl_r;       // Filtered external level

   // External clock crosses into the system domain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_sync_r <= 3'h0;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], refresh_clock_pin_in};
      end
   end

   // Filter glitches shorter than one sample
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_lvl_r <= 1'b0;
      end else if (ext_sync_r[1] == ext_sync_r[2]) begin
         ext_lvl_r <= ext_sync_r[2];
      end
   end

   // ---------------- Refresh rotation ----------------
   logic       refr_clk;        // Selected refresh clock
   logic       refr_prev_r;     // Previous selected level
   rvsp_chan_t idx_r;           // Channel being refreshed
   logic       ctrl_en_r;       // Software rotation enable
   logic       refr_fall;       // Falling refresh edge

   assign refr_clk  = (src_r == RVSP_SRC_EXT) ? ext_lvl_r : osc_r;
   assign refr_fall = refr_prev_r && !refr_clk;

   // Remember last level for edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         refr_prev_r <= 1'b0;
      end else begin
         refr_prev_r <= refr_clk;
      end
   end

   // Advance one channel per falling refresh edge, wrapping after ten
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idx_r <= 4'h0;
      end else if (refr_fall && ctrl_en_r) begin
         idx_r <= (idx_r == 4'(`RVSP_NUM_CHAN - 1)) ? 4'h0 : idx_r + 4'h1;
      end
   end

   // Present the slot being refreshed; data from flip-flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         refresh_channel <= 4'h0;
         refresh_code    <= 10'h000;
         refresh_strobe  <= 1'b0;
      end else begin
         refresh_strobe <= refr_fall && ctrl_en_r;
         if (refr_fall && ctrl_en_r) begin
            refresh_channel <= idx_r;
            refresh_code    <= code_r[idx_r];
         end
      end
   end

   // ---------------- AXI4-Lite slave ----------------
   logic        wr_go;          // Write address and data both offered
   logic        rd_go;          // Read address taken
   logic [4:0]  rd_slot;        // Code slot of the read address
   logic [31:0] rd_data;        // Read mux
   logic        rd_hit;         // Read address mapped

   // Both halves are taken in the same cycle, so either order works
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Control register: only the rotation enable is writable
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_en_r <= `RVSP_CTRL_RESET;
      end else if (wr_go && s_axi_awaddr == `RVSP_OFS_CTRL && s_axi_wstrb[0]) begin
         ctrl_en_r <= s_axi_wdata[`RVSP_CTRL_REFR_EN];
      end
   end

   // Write response; unmapped and read-only slots answer with error
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RVSP_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (s_axi_awaddr == `RVSP_OFS_CTRL) ? `RVSP_RESP_OKAY : `RVSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign rd_slot = code_slot(s_axi_araddr);

   // Read decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (rd_slot != 5'h1f) begin
         rd_data = {22'h000000, code_r[rd_slot[3:0]]};
      end else begin
         unique case (s_axi_araddr)
            `RVSP_OFS_CTRL: begin
               rd_data[`RVSP_CTRL_REFR_EN] = ctrl_en_r;
            end
            `RVSP_OFS_STATUS: begin
               rd_data[`RVSP_STAT_SRC]                         = src_r;
               rd_data[`RVSP_STAT_OE]                          = refresh_clock_pin_oe;
               rd_data[`RVSP_STAT_IDX_LO +: 4]                 = idx_r;
               rd_data[`RVSP_STAT_REJ_LO +: 8]                 = reject_r;
            end
            `RVSP_OFS_LAST: begin
               rd_data[15:0] = last_r;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RVSP_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_hit ? `RVSP_RESP_OKAY : `RVSP_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : rvsp_top

// file: tb/rvsp_top_chk.sv
`timescale 1ns/1ns
module rvsp_top_chk (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Serial side
   input wire logic       load_strobe_n,
   input wire logic       serial_chain_out,
   // Refresh side
   input wire logic       refresh_clock_pin_oe,
   input wire logic [3:0] refresh_channel,
   input wire logic       refresh_strobe,
   input wire logic       refresh_source_select,
   // Bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped early");
   property p_wans; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
   a_wans: assert property (p_wans) else $error("write not answered next cycle");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read not answered next cycle");
   property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rblk: assert property (p_rblk) else $error("read taken while one pending");
   // Gated clock must leave the chain output still
   property p_gate; load_strobe_n && $past(load_strobe_n) |-> $stable(serial_chain_out); endproperty
   a_gate: assert property (p_gate) else $error("chain output moved with strobe high");
   property p_pulse; refresh_strobe |=> !refresh_strobe; endproperty
   a_pulse: assert property (p_pulse) else $error("refresh strobe longer than a cycle");
   property p_rot; !$stable(refresh_channel) |-> refresh_strobe && refresh_channel < 4'ha; endproperty
   a_rot: assert property (p_rot) else $error("refresh channel moved off a slot");
   property p_oe; refresh_clock_pin_oe |-> !refresh_source_select; endproperty
   a_oe: assert property (p_oe) else $error("pin driven in external mode");
endmodule : rvsp_top_chk

bind rvsp_top rvsp_top_chk i_chk (.*);

// file: tb/rvsp_host_model.sv
`timescale 1ns/1ns
module rvsp_host_model (
   // Serial port towards the device
   output logic      shift_clk,
   output logic      load_strobe_n,
   output logic      serial_in,
   // Chain output coming back
   input wire logic  serial_chain_out
);
   logic seen [1:64];  // Chain output after each falling edge
   // Idle with clock low and strobe high
   initial begin
      shift_clk = 1'b0;
      load_strobe_n = 1'b1;
      serial_in = 1'b0;
   end
   // Shifts n bits, bit n-1 first, then raises the strobe
   task automatic xfer(input logic [31:0] bits, input int n);
      #5 load_strobe_n = 1'b0; // Clock is already low
      // Bench link clock is 48 ns, faster than a real host may run
      for (int k = 1; k <= n; k++) begin
         #12 serial_in = bits[n-k]; // MSB first, farthest frame first
         if (k > 1) seen[k-1] = serial_chain_out;
         #12 shift_clk = 1'b1;
         #24 shift_clk = 1'b0;
      end
      #12 if (n > 0) seen[n] = serial_chain_out;
      #12 load_strobe_n = 1'b1; // Rise loads every chained device
      serial_in = ~serial_in;   // Data no longer held
   endtask : xfer
   // Clock edges with strobe high, data wiggling
   task automatic stray(input int n);
      repeat (n) begin
         #24 shift_clk = 1'b1;
         serial_in = ~serial_in;
         #24 shift_clk = 1'b0;
      end
   endtask : stray
endmodule : rvsp_host_model

// file: tb/ref_voltage_serial_programmer_test.sv
`timescale 1ns/1ns
module ref_voltage_serial_programmer_test;
   import rvsp_pkg::*;
   logic        sys_clk, rst, shift_clk, load_strobe_n, serial_in, serial_chain_out;
   logic        pin_in, pin_out, pin_oe, ext_clk, rstb, rsrc;
   logic [3:0]  rchan, wstrb;
   logic [9:0]  rcode, c;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   int          n_errors = 0, check_count = 0, exp_ch = 0, nstb = 0;
   logic [33:0] rq[$];     // Expected {resp, data} per read
   logic [1:0]  wq[$];     // Expected response per write
   logic [9:0]  codes [10];
   logic [31:0] bits;
   logic [15:0] last_f;    // Frame left in the shift register
   time         t0;        // Start of an oscillator period

   rvsp_top i_dut (.sys_clk(sys_clk), .rst(rst), .shift_clk(shift_clk), .load_strobe_n(load_strobe_n),
      .serial_in(serial_in), .serial_chain_out(serial_chain_out), .refresh_clock_pin_in(pin_in),
      .refresh_clock_pin_out(pin_out), .refresh_clock_pin_oe(pin_oe), .refresh_channel(rchan),
      .refresh_code(rcode), .refresh_strobe(rstb), .refresh_source_select(rsrc), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rvsp_host_model i_host (.shift_clk(shift_clk), .load_strobe_n(load_strobe_n), .serial_in(serial_in),
      .serial_chain_out(serial_chain_out));

   // Pin level: device when enabled, else a 10 us external clock
   assign pin_in = pin_oe ? pin_out : ext_clk;
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      ext_clk = 1'b0;
      #3;
      forever #5000 ext_clk = ~ext_clk;
   end

   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Monitor takes the oldest note for each answer
   always @(posedge sys_clk) begin
      if (bvalid && bready) chk("bresp", wq.pop_front(), bresp);
      if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
      if (rstb) begin
         chk("refresh channel", 34'(exp_ch), rchan);
         chk("refresh code", codes[exp_ch], rcode);
         exp_ch = (exp_ch + 1) % 10;
         nstb++;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      wq.push_back(r);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge sys_clk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (!bvalid) @(posedge sys_clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge sys_clk);
      rready <= 1'b0;
   endtask : rd

   task automatic frame(input logic [15:0] f);
      i_host.xfer({16'h0, f}, 16);
      repeat (8) @(posedge sys_clk);
   endtask : frame

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   initial begin
      #400000;
      n_errors++;
      summarize();
   end

   initial begin
      void'($urandom(32'h6c403e8c));
      rst = 1'b1;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 53'h0;
      wstrb = 4'hf;
      foreach (codes[i]) codes[i] = 10'h0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h04, 32'h0, 2'h0);
      rd(8'h00, 32'h1, 2'h0);
      rd(8'h0c, 32'h0, 2'h2);
      wr(8'h04, 32'hffff, 2'h2);
      wr(8'h00, 32'h0, 2'h0);
      rd(8'h00, 32'h0, 2'h0);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         c = 10'($urandom);
         frame({2'b00, 4'(i), c});
         codes[i] = c;
      end
      for (int i = 0; i < 10; i++) rd(8'(8'h40 + 4 * i), {22'h0, codes[i]}, 2'h0);
      rd(8'h04, 32'h2, 2'h0);
      $display("test channels done");
      i_host.stray(4);
      last_f = {2'b00, 4'h9, codes[9]};
      bits = {16'ha5c3, 16'h0eaa};
      i_host.xfer(bits, 32);
      repeat (8) @(posedge sys_clk);
      codes[3] = 10'h2aa;
      // Early bits show the old frame, untouched by the stray edges
      for (int j = 1; j <= 32; j++) begin
         chk("chain bit", 34'(j < 16 ? last_f[15-j] : bits[47-j]), 34'(i_host.seen[j]));
      end
      rd(8'h4c, 32'h2aa, 2'h0);
      rd(8'h08, 32'h0eaa, 2'h0);
      $display("test chain done");
      for (int i = 10; i <= 16; i++) frame(i == 16 ? {2'b11, 4'h1, 10'h3ff} : {2'b00, 4'(i), 10'h155});
      rd(8'h44, {22'h0, codes[1]}, 2'h0);
      rd(8'h04, 32'h0702, 2'h0);
      $display("test refusals done");
      c = 10'($urandom);
      frame({2'b01, 4'h0, c});
      codes[0] = c;
      rd(8'h04, 32'h0701, 2'h0);
      chk("source select", 34'h1, rsrc);
      wr(8'h00, 32'h1, 2'h0);
      wstrb <= 4'he;
      wr(8'h00, 32'h0, 2'h0);
      rd(8'h00, 32'h1, 2'h0);
      wstrb <= 4'hf;
      repeat (15000) @(posedge sys_clk);
      chk("refresh count", 34'h1, 34'(nstb >= 10));
      frame({2'b00, 4'h0, c});
      chk("pin drive", 34'h1, pin_oe);
      chk("source select", 34'h0, rsrc);
      @(posedge pin_out);
      t0 = $time;
      @(posedge pin_out);
      chk("osc period", 34'h1, 34'(($time - t0) > 45000 && ($time - t0) < 50000));
      $display("test refresh done");
      summarize();
   end
endmodule : ref_voltage_serial_programmer_test
